// ---- sim/pds_front_end_model.sv ----
`timescale 1ns/100ps
// front end: answers each conversion start, promptly or late
module pds_front_end_model #(
  parameter int unsigned DW = 12
) (
  input  wire logic              ref_clk,
  input  wire logic              conv_start,
  input  wire logic              slow,
  output logic                   conv_ready,
  output logic [4*DW-1:0]        conv_data
);
  initial begin
    conv_ready = 1'b0;
    conv_data  = '0;
  end
  // idle data toggles so a stale word never looks valid
  always @(posedge ref_clk) begin
    if (conv_start === 1'b1) begin
      repeat (slow ? 3 : 0) begin
        conv_data <= ~conv_data;
        @(posedge ref_clk);
      end
      conv_ready <= 1'b1;
      // lg_q, lg_i, hg_q, hg_i packed in one word
      conv_data  <= (4*DW)'({$urandom, $urandom});
      @(posedge ref_clk);
      conv_ready <= 1'b0;
    end
    conv_data <= ~conv_data;
  end
endmodule : pds_front_end_model

// ---- sim/pulsed_doppler_sequencer_tb.sv ----
`timescale 1ns/100ps
module pulsed_doppler_sequencer_tb;
  import pds_pkg::*;
  localparam int unsigned ADV_F = 20;
  localparam int unsigned PER   = 2000;
  logic ref_clk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, slow = 1'b1, rd_v = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0]  htrans = 2'b00;
  logic        hreadyout, hresp, sup_n, tx_en, ref_s, ref_h, strobe;
  logic        amp1, amp2, conv_start, conv_ready, irq;
  logic [47:0] conv_data;
  logic [31:0] pq[$], rd_q[$];
  int unsigned err_total = 0, tests_run = 0, cyc = 0, n_pulse = 0;
  int unsigned adv_n = 0, wid_n = 0, conv_n = 0, adv_c = 0, t0 = 0, t5 = 0;
  int unsigned r;
  logic        sup_q = 1'b1;

  always #50 ref_clk = ~ref_clk;

  pds_top #(.ADV_FIRST(ADV_F), .DEPTH(256), .DW(12)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hsel(1'b1),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .front_end_supply_enable_n(sup_n), .tx_enable(tx_en),
    .ref_supply_enable(ref_s), .ref_hold_enable(ref_h),
    .baseband_hold_strobe(strobe), .amp_stage_one_enable(amp1),
    .amp_stage_two_enable(amp2), .conv_start(conv_start),
    .conv_ready(conv_ready), .conv_data(conv_data), .irq(irq));

  pds_front_end_model #(.DW(12)) u_fe (
    .ref_clk(ref_clk), .conv_start(conv_start), .slow(slow),
    .conv_ready(conv_ready), .conv_data(conv_data));

  task automatic close_out;
    if (err_total == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // single ahb-lite transfer, read data noted for the monitor
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NSEQ;
    hwrite <= w;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    htrans <= 2'b00;
    hwdata <= w ? d : 32'h0;
    rd_v   <= ~w;
    if (!w) rd_q.push_back(d);
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    rd_v   <= 1'b0;
  endtask : ahb

  // one frame: first advance short (ADV_F), the four later ones ADV_NEXT_CYC
  task automatic push_frame(input int unsigned w);
    pq.push_back({16'(ADV_F), 16'(w)});
    repeat (4) pq.push_back({16'(ADV_NEXT_CYC), 16'(w)});
  endtask : push_frame

  task automatic wait_p(input int unsigned k);
    while (n_pulse < k) @(posedge ref_clk);
  endtask : wait_p

  // monitor: pin relations each cycle, pulse shape against notes
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
    if (rst_n === 1'b1) begin
      chk(tx_en, !sup_n);
      chk(ref_h, ref_s);
      chk(strobe & sup_n, 1'b0);
      chk(ref_s & ~sup_n, 1'b0);
      chk(amp1 & ~amp2, 1'b0);
      if (sup_q && !sup_n) begin
        adv_c = adv_n;
        adv_n = 0;
        wid_n = 0;
        conv_n = 0;
        if (n_pulse == 0) t0 = cyc;
        if (n_pulse == 5) t5 = cyc;
      end
      if (ref_s) adv_n++;
      if (!sup_n) begin
        wid_n++;
        conv_n += conv_start;
      end
      if (!sup_q && sup_n) begin
        if (pq.size() == 0) chk(32'h1, 32'h0);
        else chk({adv_c[15:0], wid_n[15:0]}, pq.pop_front());
        chk(conv_n, 32'h1);
        n_pulse++;
      end
    end
    sup_q = sup_n;
    if (rd_v && hreadyout) chk(hrdata, rd_q.pop_front());
  end

  initial begin
    void'($urandom(32'h97ba1163));
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    ahb(1'b0, 8'h40, 32'h0);
    ahb(1'b1, REG_PERIOD, PER);
    ahb(1'b1, REG_PRI, 32'h10);
    ahb(1'b1, REG_ONTIME, 32'h2);
    ahb(1'b1, REG_SH, 32'h0201);
    ahb(1'b1, REG_COUNT, 32'h0203);
    ahb(1'b1, REG_MASK, 32'h0);
    push_frame(20);
    ahb(1'b1, REG_CTRL, 32'h3);
    repeat (3) @(posedge ref_clk);
    chk({amp1, amp2}, 2'b11);
    wait_p(1);
    r = $urandom_range(10, 1);
    ahb(1'b1, REG_ONTIME, r);
    ahb(1'b1, REG_ONTIME, 32'hb);
    ahb(1'b1, REG_ONTIME, 32'h0);
    ahb(1'b0, REG_ONTIME, r);
    push_frame(r * CYC_PER_US);
    wait_p(5);
    repeat (20) @(posedge ref_clk);
    chk(irq, 1'b0);
    // last pulse index 4, three samples kept, sequencer idle
    ahb(1'b0, REG_STATE, 32'h4030);
    ahb(1'b1, REG_MASK, 32'h2);
    repeat (3) @(posedge ref_clk);
    chk(irq, 1'b1);
    ahb(1'b1, REG_STAT, 32'h2);
    repeat (3) @(posedge ref_clk);
    chk(irq, 1'b0);
    ahb(1'b0, REG_STAT, 32'h1);
    ahb(1'b0, REG_PERIOD, PER);
    slow <= 1'b0;
    wait_p(10);
    chk(t5 - t0, PER);
    repeat (20) @(posedge ref_clk);
    chk(irq, 1'b1);
    ahb(1'b1, REG_CTRL, 32'h4);
    repeat (3) @(posedge ref_clk);
    chk({amp1, amp2}, 2'b01);
    repeat (2500) @(posedge ref_clk);
    chk(pq.size(), 32'h0);
    chk(n_pulse, 32'ha);
    close_out();
  end
endmodule : pulsed_doppler_sequencer_tb

// ---- verilog/pds_pkg.sv ----
// Operation
// - frame timer starts each frame's pulses
// - pulses per frame equal samples plus skips
// - supply and transmit on only during pulse
// - supply enable low; falling edge is T0
// - pulse on-time settable from 1 to 10 us
// - reference enables 1 ms first, 20 us later
// - hold capacitor recharged right before pulses
// - sample strobe briefly inside each pulse
// - amplifier enables; stage one powers stage two
// - pulse series then frame off-time
// - conversion trigger equidistant, starts with pulses
// - four channels: I/Q at high and low gain
// - move results; stop and flag at count
// - skip-count samples excluded from delivered data
// - at count halt pulses and triggers
package pds_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned CLK_NS        = 1_000_000_000 / CLK_HZ;
  localparam int unsigned ADV_FIRST_US  = 1000;
  localparam int unsigned ADV_NEXT_US   = 20;
  localparam int unsigned ADV_FIRST_CYC = ADV_FIRST_US * 1000 / CLK_NS;
  localparam int unsigned ADV_NEXT_CYC  = ADV_NEXT_US * 1000 / CLK_NS;
  localparam int unsigned ON_MIN_US     = 1;
  localparam int unsigned ON_MAX_US     = 10;
  localparam int unsigned CYC_PER_US    = 1000 / CLK_NS;
  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_PERIOD = 8'h04;
  localparam logic [7:0] REG_PRI    = 8'h08;
  localparam logic [7:0] REG_ONTIME = 8'h0c;
  localparam logic [7:0] REG_SH     = 8'h10;
  localparam logic [7:0] REG_COUNT  = 8'h14;
  localparam logic [7:0] REG_STAT   = 8'h18;
  localparam logic [7:0] REG_MASK   = 8'h1c;
  localparam logic [7:0] REG_STATE  = 8'h20;
  localparam logic [7:0] REG_DATA   = 8'h24;
  localparam logic [7:0] REG_RDIDX  = 8'h28;
  // field positions
  localparam int unsigned CTRL_RUN  = 0;
  localparam int unsigned CTRL_AMP1 = 1;
  localparam int unsigned CTRL_AMP2 = 2;
  localparam int unsigned ST_FRAME  = 0;
  localparam int unsigned ST_DONE   = 1;
  localparam int unsigned ST_ERR    = 2;
  localparam int unsigned ST_W      = 3;
  // reset values
  localparam logic [31:0] RST_PERIOD = 32'h0000_7530;
  localparam logic [15:0] RST_PRI    = 16'h0320;
  localparam logic [3:0]  RST_ONTIME = 4'h5;
  localparam logic [7:0]  RST_SHOFS  = 8'h14;
  localparam logic [7:0]  RST_SHW    = 8'h0a;
  localparam logic [7:0]  RST_NSAMP  = 8'h10;
  localparam logic [7:0]  RST_NSKIP  = 8'h02;
  localparam logic [1:0]  HTRANS_NSEQ = 2'b10;
  typedef enum logic [1:0] {PDS_IDLE, PDS_ADV, PDS_PULSE, PDS_GAP} pds_state_t;
endpackage : pds_pkg

// ---- verilog/pds_top.sv ----
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
module pds_top #(
  parameter int unsigned ADV_FIRST = pds_pkg::ADV_FIRST_CYC,
  parameter int unsigned DEPTH     = 256,
  parameter int unsigned DW        = 12
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hsel,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic                      front_end_supply_enable_n,
  output logic                      tx_enable,
  output logic                      ref_supply_enable,
  output logic                      ref_hold_enable,
  output logic                      baseband_hold_strobe,
  output logic                      amp_stage_one_enable,
  output logic                      amp_stage_two_enable,
  output logic                      conv_start,
  input  wire logic                 conv_ready,
  input  wire logic [4*DW-1:0]      conv_data,
  output logic                      irq
);
  import pds_pkg::*;

  // bus address phase capture
  logic        wr_pend_q, rd_pend_q;
  logic [7:0]  addr_q;
  wire         bus_go = hsel & hready & (htrans == HTRANS_NSEQ);

  // settings (live) and frame shadows
  logic [31:0] period_q;
  logic [15:0] pri_q;
  logic [3:0]  ontime_q;
  logic [7:0]  shofs_q, shw_q, nsamp_q, nskip_q;
  logic [2:0]  ctrl_q;
  logic [15:0] pri_s_q;
  logic [3:0]  ontime_s_q;
  logic [7:0]  shofs_s_q, shw_s_q, nsamp_s_q, nskip_s_q;
  logic [ST_W-1:0] stat_q, mask_q;
  logic [7:0]  rdidx_q;

  // sequencer state
  pds_state_t  state_q;
  logic [31:0] ftim_q;
  logic [15:0] cnt_q;
  logic [8:0]  pulse_q;
  logic [7:0]  wr_q;
  logic        first_q, cap_q;
  logic [4*DW-1:0] mem_q [DEPTH];
  logic [31:0] rd_word;

  // two-stage sync of converter handshake and data
  logic        crdy_s1_q, crdy_s2_q;
  logic [4*DW-1:0] cdat_s1_q, cdat_s2_q;
  always_ff @(posedge ref_clk) begin
    crdy_s1_q <= conv_ready;
    crdy_s2_q <= crdy_s1_q;
    cdat_s1_q <= conv_data;
    cdat_s2_q <= cdat_s1_q;
  end

  // derived timing
  wire [15:0] on_cyc = 16'(ontime_s_q) * 16'(CYC_PER_US);
  wire [8:0]  total  = 9'(nsamp_s_q) + 9'(nskip_s_q);
  wire [31:0] adv_len = first_q ? 32'(ADV_FIRST) : 32'(ADV_NEXT_CYC);
  wire        frame_tick = ctrl_q[CTRL_RUN] & (ftim_q == 32'h0);
  // one extra advance cycle so the reference lead is exactly adv_len
  wire        adv_end = (state_q == PDS_ADV) && (32'(cnt_q) >= adv_len);
  wire        pulse_end = (state_q == PDS_PULSE) && (cnt_q + 16'h1 >= on_cyc);
  wire        last_pulse = (pulse_q + 9'h1 >= total);
  wire        gap_end = (state_q == PDS_GAP) && (cnt_q + 16'h1 >= pri_s_q);
  wire        keep = (pulse_q >= 9'(nskip_s_q));
  wire        store = cap_q & crdy_s2_q & keep & (wr_q < nsamp_s_q);
  wire        done_ev = store & (wr_q + 8'h1 == nsamp_s_q);
  wire        err_ev = frame_tick & (state_q != PDS_IDLE);
  wire [ST_W-1:0] ev = {err_ev, done_ev, frame_tick};
  wire [ST_W-1:0] w1c = (wr_pend_q && addr_q == REG_STAT) ?
                        hwdata[ST_W-1:0] : '0;
  wire        ontime_ok = (hwdata[3:0] >= 4'(ON_MIN_US)) &&
                          (hwdata[3:0] <= 4'(ON_MAX_US));

  // frame period timer, free-running while enabled
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !ctrl_q[CTRL_RUN] || ftim_q == 32'h0)
      ftim_q <= (period_q == 32'h0) ? 32'h0 : period_q - 32'h1;
    else
      ftim_q <= ftim_q - 32'h1;
  end

  // pulse sequencer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= PDS_IDLE;
      cnt_q   <= 16'h0;
      pulse_q <= 9'h0;
      first_q <= 1'b1;
      cap_q   <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 16'h1;
      case (state_q)
        PDS_IDLE: begin
          if (frame_tick && total != 9'h0) begin
            state_q <= PDS_ADV;
            cnt_q   <= 16'h0;
            pulse_q <= 9'h0;
            first_q <= 1'b1;
          end
        end
        PDS_ADV: begin
          if (adv_end) begin
            state_q <= PDS_PULSE;
            cnt_q   <= 16'h0;
            cap_q   <= 1'b1;
          end else if (!first_q && cnt_q == 16'hffff)
            cnt_q <= cnt_q;
        end
        PDS_PULSE: begin
          if (pulse_end) begin
            first_q <= 1'b0;
            cap_q   <= 1'b0;
            cnt_q   <= 16'h0;
            if (last_pulse)
              state_q <= PDS_IDLE;
            else
              state_q <= PDS_GAP;
          end
        end
        PDS_GAP: begin
          if (gap_end || 32'(pri_s_q) <= 32'(ADV_NEXT_CYC) + 32'(on_cyc)) begin
            state_q <= PDS_ADV;
            cnt_q   <= 16'h0;
            pulse_q <= pulse_q + 9'h1;
          end
        end
        default: state_q <= PDS_IDLE;
      endcase
    end
  end

  // pin drivers, all registered
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      front_end_supply_enable_n <= 1'b1;
      tx_enable            <= 1'b0;
      ref_supply_enable    <= 1'b0;
      ref_hold_enable      <= 1'b0;
      baseband_hold_strobe <= 1'b0;
      conv_start           <= 1'b0;
      amp_stage_one_enable <= 1'b0;
      amp_stage_two_enable <= 1'b0;
    end else begin
      front_end_supply_enable_n <= !(adv_end || (state_q == PDS_PULSE &&
                                     !pulse_end));
      tx_enable <= adv_end || (state_q == PDS_PULSE && !pulse_end);
      ref_supply_enable <= (state_q == PDS_ADV) && !adv_end;
      ref_hold_enable   <= (state_q == PDS_ADV) && !adv_end;
      baseband_hold_strobe <= (state_q == PDS_PULSE) && !pulse_end &&
                              (cnt_q + 16'h1 >= 16'(shofs_s_q)) &&
                              (cnt_q + 16'h1 < 16'(shofs_s_q) +
                               16'(shw_s_q));
      conv_start <= (state_q == PDS_PULSE) &&
                    (cnt_q + 16'h1 == 16'(shofs_s_q) + 16'(shw_s_q));
      amp_stage_one_enable <= ctrl_q[CTRL_AMP1];
      amp_stage_two_enable <= ctrl_q[CTRL_AMP2] | ctrl_q[CTRL_AMP1];
    end
  end

  // latch frame settings at frame start
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pri_s_q    <= RST_PRI;
      ontime_s_q <= RST_ONTIME;
      shofs_s_q  <= RST_SHOFS;
      shw_s_q    <= RST_SHW;
      nsamp_s_q  <= RST_NSAMP;
      nskip_s_q  <= RST_NSKIP;
    end else if (frame_tick && state_q == PDS_IDLE) begin
      pri_s_q    <= pri_q;
      ontime_s_q <= ontime_q;
      shofs_s_q  <= shofs_q;
      shw_s_q    <= shw_q;
      nsamp_s_q  <= nsamp_q;
      nskip_s_q  <= nskip_q;
    end
  end

  // acquisition buffer, four channels packed per word
  always_ff @(posedge ref_clk) begin
    if (store)
      mem_q[wr_q] <= cdat_s2_q;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n || (frame_tick && state_q == PDS_IDLE))
      wr_q <= 8'h0;
    else if (store)
      wr_q <= wr_q + 8'h1;
  end

  // bus address phase
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h0;
    end else begin
      wr_pend_q <= bus_go & hwrite;
      rd_pend_q <= bus_go & !hwrite;
      if (bus_go)
        addr_q <= haddr[7:0];
    end
  end

  // register writes; event set wins over clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_q   <= 3'h0;
      period_q <= RST_PERIOD;
      pri_q    <= RST_PRI;
      ontime_q <= RST_ONTIME;
      shofs_q  <= RST_SHOFS;
      shw_q    <= RST_SHW;
      nsamp_q  <= RST_NSAMP;
      nskip_q  <= RST_NSKIP;
      mask_q   <= '0;
      rdidx_q  <= 8'h0;
      stat_q   <= '0;
    end else begin
      stat_q <= (stat_q & ~w1c) | ev;
      if (wr_pend_q) begin
        case (addr_q)
          REG_CTRL:   ctrl_q   <= hwdata[2:0];
          REG_PERIOD: period_q <= hwdata;
          REG_PRI:    pri_q    <= hwdata[15:0];
          REG_ONTIME: if (ontime_ok) ontime_q <= hwdata[3:0];
          REG_SH: begin
            shofs_q <= hwdata[7:0];
            shw_q   <= hwdata[15:8];
          end
          REG_COUNT: begin
            nsamp_q <= hwdata[7:0];
            nskip_q <= hwdata[15:8];
          end
          REG_MASK:  mask_q  <= hwdata[ST_W-1:0];
          REG_RDIDX: rdidx_q <= hwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  // read mux
  // read decoded in the address phase so data stands in the data phase
  wire [4*DW-1:0] mem_word = mem_q[rdidx_q];
  wire [7:0]      rd_addr  = haddr[7:0];
  wire            rd_go    = bus_go & !hwrite;
  always_comb begin
    rd_word = 32'h0;
    case (rd_addr)
      REG_CTRL:   rd_word = {29'h0, ctrl_q};
      REG_PERIOD: rd_word = period_q;
      REG_PRI:    rd_word = {16'h0, pri_q};
      REG_ONTIME: rd_word = {28'h0, ontime_q};
      REG_SH:     rd_word = {16'h0, shw_q, shofs_q};
      REG_COUNT:  rd_word = {16'h0, nskip_q, nsamp_q};
      REG_STAT:   rd_word = {{(32-ST_W){1'b0}}, stat_q};
      REG_MASK:   rd_word = {{(32-ST_W){1'b0}}, mask_q};
      REG_STATE:  rd_word = {11'h0, pulse_q, wr_q, 2'h0, state_q};
      REG_DATA:   rd_word = 32'(mem_word[2*DW-1:0]);
      REG_RDIDX:  rd_word = 32'(mem_word[4*DW-1:2*DW]);
      default:    rd_word = 32'h0;
    endcase
  end

  // data phase outputs and interrupt
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hrdata <= 32'h0;
      irq    <= 1'b0;
    end else begin
      hrdata <= rd_go ? rd_word : 32'h0;
      irq    <= |(((stat_q & ~w1c) | ev) & mask_q);
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // pulse shape: at least eight cycles low, transmit in step
  AST_PULSE_LEN: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    $fell(front_end_supply_enable_n) |->
    !front_end_supply_enable_n [*8])
    else $error("pulse too short");
  AST_TX_WITH_SUPPLY: assert property (@(posedge ref_clk)
    disable iff (!rst_n) tx_enable == !front_end_supply_enable_n)
    else $error("transmit not aligned to supply");
  AST_SUPPLY_POL: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    state_q == PDS_IDLE && $past(state_q) == PDS_IDLE |=>
    front_end_supply_enable_n)
    else $error("supply on while idle");

  // reference hold: charged before the pulse, quiet during it
  AST_REF_OFF_IN_PULSE: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    !front_end_supply_enable_n |-> !ref_supply_enable && !ref_hold_enable)
    else $error("reference on during pulse");
  AST_REF_PAIR: assert property (@(posedge ref_clk)
    disable iff (!rst_n) ref_supply_enable == ref_hold_enable)
    else $error("reference enables apart");
  AST_REF_BEFORE: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    $fell(front_end_supply_enable_n) |-> $past(ref_hold_enable))
    else $error("no recharge before pulse");

  // strobe, trigger and amplifier enables
  AST_STROBE_IN_PULSE: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    baseband_hold_strobe |-> !front_end_supply_enable_n)
    else $error("strobe outside pulse");
  AST_CONV_IN_PULSE: assert property (@(posedge ref_clk)
    disable iff (!rst_n) conv_start |-> $past(state_q) == PDS_PULSE)
    else $error("trigger outside pulse");
  AST_CONV_ONE: assert property (@(posedge ref_clk)
    disable iff (!rst_n) conv_start |=> !conv_start)
    else $error("trigger longer than one cycle");
  AST_AMP_WIRING: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    amp_stage_one_enable |-> amp_stage_two_enable)
    else $error("stage two off with stage one");

  // acquisition count, skip and halt
  AST_DONE_COUNT: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    done_ev |=> stat_q[ST_DONE] && wr_q == nsamp_s_q)
    else $error("done without full count");
  AST_NO_STORE_AFTER: assert property (@(posedge ref_clk)
    disable iff (!rst_n) wr_q == nsamp_s_q |-> !store)
    else $error("store past count");
  AST_HALT: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    state_q == PDS_IDLE |=> !conv_start && !baseband_hold_strobe)
    else $error("trigger while halted");
  AST_SKIP: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    store |-> pulse_q >= 9'(nskip_s_q))
    else $error("skipped sample stored");

  // frame sequencing and settings
  AST_START: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    frame_tick && state_q == PDS_IDLE && total != 9'h0 |=>
    state_q == PDS_ADV)
    else $error("frame did not start");
  AST_COUNT: assert property (@(posedge ref_clk)
    disable iff (!rst_n) pulse_q <= total)
    else $error("too many pulses");
  AST_OFFTIME: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    pulse_end && last_pulse |=> state_q == PDS_IDLE)
    else $error("no off-time after series");
  AST_LATCH: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    state_q != PDS_IDLE && $past(state_q) != PDS_IDLE |->
    $stable(pri_s_q))
    else $error("settings changed mid frame");
  AST_ONTIME: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    ontime_q >= 4'(ON_MIN_US) && ontime_q <= 4'(ON_MAX_US))
    else $error("on-time out of range");

  // read data only in a read data phase
  AST_RD_IDLE: assert property (@(posedge ref_clk)
    disable iff (!rst_n) !rd_pend_q |-> hrdata == 32'h0)
    else $error("read data outside data phase");
endmodule : pds_top
